// File: logic/rtb_test_regs.sv
`timescale 1ns/1ps
`default_nettype none
module rtb_test_regs
	import rtb_pkg::*;
(
	input  wire logic        i_sys_clk,      // 25 MHz system clock
	input  wire logic        i_srst,         // Synchronous reset
	input  wire logic [5:0]  i_addr,         // Register address
	input  wire logic        i_wr_en,        // Write strobe
	input  wire logic [15:0] i_wr_data,      // Write word
	input  wire logic        i_rd_en,        // Read strobe
	output logic      [15:0] o_rd_data,      // Read word
	output logic             o_rd_valid,     // Read word valid
	input  wire logic [5:0]  i_present_state_code, // Frame control state
	input  wire logic [6:0]  i_conv_i,       // In-phase sample
	input  wire logic [6:0]  i_conv_q,       // Quadrature sample
	input  wire logic        i_conv_enable,  // Converter enabled
	input  wire logic        i_conv_clk_raw, // Converter clock source
	output logic             o_conv_clk_en,  // Converter clock gate
	input  wire logic [5:0]  i_mod_i,
	input  wire logic [5:0]  i_mod_q,
	input  wire logic [5:0]  i_filt_i,
	input  wire logic [5:0]  i_filt_q,
	input  wire logic [5:0]  i_noise_i,
	input  wire logic [5:0]  i_noise_q,
	input  wire logic [5:0]  i_mag_i,
	input  wire logic [5:0]  i_mag_q,
	input  wire logic [5:0]  i_dump_i,
	input  wire logic [5:0]  i_dump_q,
	output logic      [5:0]  o_dac_i,        // Transmit DAC in-phase
	output logic      [5:0]  o_dac_q,        // Transmit DAC quadrature
	output logic             o_memory_selftest_run,
	input  wire logic        i_selftest_result, // Self-test result
	output logic             o_selftest_pin, // Result to chosen pin
	output logic             o_battery_monitor_test_out,
	output logic             o_analog_test_powerdown,
	output logic      [3:0]  o_analog_test_routing, // Active routing
	output logic             o_routing_active, // Module up, code valid
	output logic             o_if_loopback,  // TX IF into RX IF
	output logic             o_pin_first_to_node, // First pin on node
	output logic             o_pin_second_drives_node,
	output logic             o_pin_second_senses_node,
	input  wire logic        i_control_node_open_loop, // Synth bit
	output logic             o_node_from_loop_filter,
	output logic             o_node_from_vc_dac
);
	// ----------------------------------------------------------------
	// Block state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        clk_stop;   // Converter clock stop
		logic [2:0]  src;        // DAC source select
		logic [5:0]  ovr_i;      // In-phase override
		logic [5:0]  ovr_q;      // Quadrature override
		logic        selftest;   // Memory self-test run
		logic        batmon;     // Battery monitor test out
		logic        drive_sel;  // Control node drive select
		logic        pd;         // Analog test power down
		logic [3:0]  route;      // Analog test routing
		logic [15:0] rd_data;    // Read word
		logic        rd_valid;   // Read word valid
	} rtb_st_t;

	rtb_st_t    st_q;      // Registered state
	rtb_st_t    st_d;      // Next state
	logic [15:0] rd_word;  // Combinational read mux
	logic        wr_state; // Write to state info
	logic        loop7;    // Routing 7 active

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	// Unused bits are forced low so stray host writes never show
	// reserved read zero
	always_comb begin
		rd_word = 16'h0000;
		case (i_addr)
			ADDR_STATE_INFO: rd_word[5:0] = i_present_state_code;
			ADDR_CONV_TEST: begin
				rd_word[CLK_STOP_BIT] = st_q.clk_stop;
				rd_word[CONV_I_LSB +: 7] = i_conv_i;
				rd_word[CONV_Q_LSB +: 7] = i_conv_q;
			end
			ADDR_DAC_TEST: begin
				rd_word[SRC_LSB +: 3]   = st_q.src;
				rd_word[OVR_I_LSB +: 6] = st_q.ovr_i;
				rd_word[OVR_Q_LSB +: 6] = st_q.ovr_q;
			end
			ADDR_TOP_TEST: begin
				rd_word[SELFTEST_BIT]  = st_q.selftest;
				rd_word[BATMON_BIT]    = st_q.batmon;
				rd_word[DRIVE_SEL_BIT] = st_q.drive_sel;
				rd_word[PD_BIT]        = st_q.pd;
				rd_word[ROUTE_LSB +: 4] = st_q.route;
			end
			default: rd_word = 16'h0000;
		endcase
	end

	// State info register is read-only; flag writes for coverage
	assign wr_state = i_wr_en && (i_addr == ADDR_STATE_INFO);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// Samples and state code are never stored, so writes cannot hit them
	always_comb begin
		st_d = st_q;
		st_d.rd_valid = i_rd_en;
		if (i_rd_en) begin
			st_d.rd_data = rd_word;
		end
		if (i_wr_en) begin
			case (i_addr)
				ADDR_CONV_TEST: st_d.clk_stop = i_wr_data[CLK_STOP_BIT];
				ADDR_DAC_TEST: begin
					st_d.src   = i_wr_data[SRC_LSB +: 3];
					st_d.ovr_i = i_wr_data[OVR_I_LSB +: 6];
					st_d.ovr_q = i_wr_data[OVR_Q_LSB +: 6];
				end
				ADDR_TOP_TEST: begin
					st_d.selftest  = i_wr_data[SELFTEST_BIT];
					st_d.batmon    = i_wr_data[BATMON_BIT];
					st_d.drive_sel = i_wr_data[DRIVE_SEL_BIT];
					st_d.pd        = i_wr_data[PD_BIT];
					st_d.route     = i_wr_data[ROUTE_LSB +: 4];
				end
				default: st_d = st_d;
			endcase
		end
		if (i_srst) begin
			st_d          = '0;
			st_d.src      = SRC_RESET;
			st_d.ovr_i    = OVR_RESET;
			st_d.ovr_q    = OVR_RESET;
			st_d.pd       = PD_RESET;
			st_d.route    = ROUTE_RESET;
		end
	end

	// State register
	always_ff @(posedge i_sys_clk) begin
		st_q <= st_d;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign o_rd_data  = st_q.rd_data;
	assign o_rd_valid = st_q.rd_valid;

	assign o_conv_clk_en = i_conv_enable & i_conv_clk_raw & ~st_q.clk_stop;

	assign o_memory_selftest_run = st_q.selftest;
	assign o_selftest_pin = st_q.selftest & i_selftest_result;
	assign o_battery_monitor_test_out = st_q.batmon;
	assign o_analog_test_powerdown    = st_q.pd;

	// Codes above 8 route nothing; the pins stay idle
	// routing needs power
	assign o_routing_active = ~st_q.pd && (st_q.route <= ROUTE_MAX);
	assign o_analog_test_routing = o_routing_active ? st_q.route : 4'h0;
	assign loop7 = o_routing_active && (st_q.route == ROUTE_LOOPBACK);

	assign o_if_loopback       = loop7;
	assign o_pin_first_to_node = loop7;
	assign o_pin_second_drives_node = loop7 & st_q.drive_sel;
	assign o_pin_second_senses_node = loop7 & ~st_q.drive_sel;
	assign o_node_from_loop_filter =
		~o_pin_second_drives_node & ~i_control_node_open_loop;
	assign o_node_from_vc_dac =
		~o_pin_second_drives_node & i_control_node_open_loop;

	// ----------------------------------------------------------------
	// DAC source selection
	// ----------------------------------------------------------------
	rtb_dac_mux u_dac_mux (
		.i_sys_clk (i_sys_clk),
		.i_srst    (i_srst),
		.i_sel     (st_q.src),
		.i_ovr_i   (st_q.ovr_i),
		.i_ovr_q   (st_q.ovr_q),
		.i_conv_i  (i_conv_i),
		.i_conv_q  (i_conv_q),
		.i_mod_i   (i_mod_i),
		.i_mod_q   (i_mod_q),
		.i_filt_i  (i_filt_i),
		.i_filt_q  (i_filt_q),
		.i_noise_i (i_noise_i),
		.i_noise_q (i_noise_q),
		.i_mag_i   (i_mag_i),
		.i_mag_q   (i_mag_q),
		.i_dump_i  (i_dump_i),
		.i_dump_q  (i_dump_q),
		.o_dac_i   (o_dac_i),
		.o_dac_q   (o_dac_q)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// state code readback
	a_state_read: assert property (@(posedge i_sys_clk)
		disable iff (i_srst)
		i_rd_en && i_addr == ADDR_STATE_INFO |=>
		o_rd_data == {10'h000, $past(i_present_state_code)})
		else $error("state code read wrong");
	a_clk_stop: assert property (@(posedge i_sys_clk)
		disable iff (i_srst)
		st_q.clk_stop |-> !o_conv_clk_en)
		else $error("converter clock ran while stopped");
	a_sample_ro: assert property (@(posedge i_sys_clk)
		disable iff (i_srst)
		i_rd_en && i_addr == ADDR_CONV_TEST |=>
		o_rd_data[14:8] == $past(i_conv_i) &&
		o_rd_data[6:0] == $past(i_conv_q) && !o_rd_data[7])
		else $error("sample read wrong");
	a_src_store: assert property (@(posedge i_sys_clk)
		disable iff (i_srst)
		i_wr_en && i_addr == ADDR_DAC_TEST |=>
		st_q.src == $past(i_wr_data[14:12]))
		else $error("source select not stored");
	a_pd_reset: assert property (@(posedge i_sys_clk)
		i_srst |=> o_analog_test_powerdown && !o_memory_selftest_run &&
		!o_battery_monitor_test_out)
		else $error("test bits wrong after reset");
	a_route_gate: assert property (@(posedge i_sys_clk)
		disable iff (i_srst)
		o_analog_test_powerdown |-> !o_if_loopback &&
		o_analog_test_routing == 4'h0)
		else $error("routing active while powered down");
	a_loop_pin: assert property (@(posedge i_sys_clk)
		disable iff (i_srst)
		o_if_loopback |-> o_pin_first_to_node &&
		(o_pin_second_drives_node != o_pin_second_senses_node))
		else $error("loopback pins wrong");
	a_node_src: assert property (@(posedge i_sys_clk)
		disable iff (i_srst)
		!o_pin_second_drives_node |->
		o_node_from_vc_dac == i_control_node_open_loop)
		else $error("node source wrong");
	a_top_ro: assert property (@(posedge i_sys_clk)
		disable iff (i_srst)
		i_rd_en && i_addr == ADDR_TOP_TEST |=> o_rd_data[15:8] == 8'h00)
		else $error("reserved bits not zero");

	c_loop_drive: cover property (@(posedge i_sys_clk)
		o_pin_second_drives_node);
	c_override: cover property (@(posedge i_sys_clk)
		st_q.src == SRC_OVERRIDE);
	c_state_wr: cover property (@(posedge i_sys_clk) wr_state);
endmodule
`default_nettype wire

// File: logic/rtb_pkg.sv
`default_nettype none
package rtb_pkg;
	// ----------------------------------------------------------------
	// Register addresses on the configuration port
	// ----------------------------------------------------------------
	localparam logic [5:0] ADDR_STATE_INFO = 6'h2c; // State information
	localparam logic [5:0] ADDR_CONV_TEST  = 6'h2d; // Converter test
	localparam logic [5:0] ADDR_DAC_TEST   = 6'h2e; // Transmit DAC test
	localparam logic [5:0] ADDR_TOP_TEST   = 6'h2f; // Top-level test

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CLK_STOP_BIT  = 15; // Converter clock stop
	localparam int CONV_I_LSB    = 8;  // In-phase sample low bit
	localparam int CONV_Q_LSB    = 0;  // Quadrature sample low bit
	localparam int SRC_LSB       = 12; // DAC source select low bit
	localparam int OVR_I_LSB     = 6;  // In-phase override low bit
	localparam int OVR_Q_LSB     = 0;  // Quadrature override low bit
	localparam int SELFTEST_BIT  = 7;  // Memory self-test run
	localparam int BATMON_BIT    = 6;  // Battery monitor test out
	localparam int DRIVE_SEL_BIT = 5;  // Control node drive select
	localparam int PD_BIT        = 4;  // Analog test power down
	localparam int ROUTE_LSB     = 0;  // Analog routing low bit

	// ----------------------------------------------------------------
	// Reset values and special codes
	// ----------------------------------------------------------------
	localparam logic [2:0] SRC_RESET      = 3'h0;
	localparam logic [5:0] OVR_RESET      = 6'h00;
	localparam logic       PD_RESET       = 1'h1;
	localparam logic [3:0] ROUTE_RESET    = 4'h0;
	localparam logic [3:0] ROUTE_LOOPBACK = 4'h7; // IF loop, node on pin
	localparam logic [3:0] ROUTE_MAX      = 4'h8; // Highest routing code
	localparam logic [2:0] SRC_OVERRIDE   = 3'h1;

	// DAC data sources
	typedef enum logic [2:0] {
		SRC_MODULATOR, SRC_OVR, SRC_CONV_HIGH, SRC_FILTERED,
		SRC_NOISE, SRC_CONV_LOW, SRC_MAGNITUDE, SRC_SAMPLE_DUMP
	} rtb_src_t;
endpackage
`default_nettype wire

// File: logic/rtb_dac_mux.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Transmit DAC source selector, registered output
// ----------------------------------------------------------------
module rtb_dac_mux
	import rtb_pkg::*;
(
	input  wire logic       i_sys_clk,
	input  wire logic       i_srst,
	input  wire logic [2:0] i_sel,
	input  wire logic [5:0] i_ovr_i,
	input  wire logic [5:0] i_ovr_q,
	input  wire logic [6:0] i_conv_i,
	input  wire logic [6:0] i_conv_q,
	input  wire logic [5:0] i_mod_i,
	input  wire logic [5:0] i_mod_q,
	input  wire logic [5:0] i_filt_i,
	input  wire logic [5:0] i_filt_q,
	input  wire logic [5:0] i_noise_i,
	input  wire logic [5:0] i_noise_q,
	input  wire logic [5:0] i_mag_i,
	input  wire logic [5:0] i_mag_q,
	input  wire logic [5:0] i_dump_i,
	input  wire logic [5:0] i_dump_q,
	output logic      [5:0] o_dac_i,
	output logic      [5:0] o_dac_q
);
	typedef struct packed {
		logic [5:0] dac_i;
		logic [5:0] dac_q;
	} rtb_mux_st_t;

	rtb_mux_st_t st_q; // Registered DAC words
	rtb_mux_st_t st_d; // Next DAC words

	// Source choice per code
	// source select decode
	always_comb begin
		st_d = st_q;
		case (rtb_src_t'(i_sel))
			SRC_MODULATOR: begin
				st_d.dac_i = i_mod_i;
				st_d.dac_q = i_mod_q;
			end
			SRC_OVR: begin
				st_d.dac_i = i_ovr_i;
				st_d.dac_q = i_ovr_q;
			end
			// High six of seven converter bits
			SRC_CONV_HIGH: begin
				st_d.dac_i = i_conv_i[6:1];
				st_d.dac_q = i_conv_q[6:1];
			end
			SRC_FILTERED: begin
				st_d.dac_i = i_filt_i;
				st_d.dac_q = i_filt_q;
			end
			SRC_NOISE: begin
				st_d.dac_i = i_noise_i;
				st_d.dac_q = i_noise_q;
			end
			// Low six converter bits
			SRC_CONV_LOW: begin
				st_d.dac_i = i_conv_i[5:0];
				st_d.dac_q = i_conv_q[5:0];
			end
			SRC_MAGNITUDE: begin
				st_d.dac_i = i_mag_i;
				st_d.dac_q = i_mag_q;
			end
			SRC_SAMPLE_DUMP: begin
				st_d.dac_i = i_dump_i;
				st_d.dac_q = i_dump_q;
			end
			default: begin
				st_d.dac_i = i_mod_i;
				st_d.dac_q = i_mod_q;
			end
		endcase
		if (i_srst) begin
			st_d = '0;
		end
	end

	// State register
	always_ff @(posedge i_sys_clk) begin
		st_q <= st_d;
	end

	assign o_dac_i = st_q.dac_i;
	assign o_dac_q = st_q.dac_q;

	a_ovr_to_dac: assert property (@(posedge i_sys_clk)
		disable iff (i_srst)
		i_sel == SRC_OVERRIDE |=> o_dac_i == $past(i_ovr_i))
		else $error("override not driven to dac");
	a_src_low: assert property (@(posedge i_sys_clk)
		disable iff (i_srst)
		i_sel == 3'h5 |=> o_dac_q == $past(i_conv_q[5:0]))
		else $error("converter low bits not selected");
endmodule
`default_nettype wire

// File: test/rtb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Host side of the configuration port
// ----------------------------------------------------------------
module rtb_host_model
	import rtb_pkg::*;
(
	input  wire logic        i_sys_clk,  // System clock
	input  wire logic [15:0] i_rd_data,  // Read word
	input  wire logic        i_rd_valid, // Read word valid
	output logic      [5:0]  o_addr,     // Register address
	output logic             o_wr_en,    // Write strobe
	output logic      [15:0] o_wr_data,  // Write word
	output logic             o_rd_en     // Read strobe
);
	// Idle bus shows a junk address, never a mapped one
	initial begin
		o_addr    = 6'h3f;
		o_wr_en   = 1'b0;
		o_wr_data = 16'h0000;
		o_rd_en   = 1'b0;
	end

	// power and pin termination live outside this bank
	function automatic logic [15:0] keep(input logic [5:0] a);
		case (a)
			ADDR_STATE_INFO: keep = 16'h003f;
			ADDR_CONV_TEST:  keep = 16'hff7f;
			ADDR_DAC_TEST:   keep = 16'h7fff;
			ADDR_TOP_TEST:   keep = 16'h00ff;
			default:         keep = 16'hffff;
		endcase
	endfunction

	// One-word write, taken at the second edge
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge i_sys_clk);
		o_addr    <= a;
		o_wr_data <= d & keep(a);
		o_wr_en   <= 1'b1;
		@(posedge i_sys_clk);
		o_wr_en   <= 1'b0;
		o_addr    <= ~a;
		o_wr_data <= ~d;
	endtask

	// One-word read, answer sampled 1 ns after the taking edge
	task automatic rd(input logic [5:0] a, output logic [15:0] d,
		output logic v);
		@(posedge i_sys_clk);
		o_addr  <= a;
		o_rd_en <= 1'b1;
		@(posedge i_sys_clk);
		o_rd_en <= 1'b0;
		o_addr  <= ~a;
		#1;
		d = i_rd_data;
		v = i_rd_valid;
	endtask
endmodule
`default_nettype wire

// File: test/radio_test_register_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none
module radio_test_register_bank_tb;
	import rtb_pkg::*;
	logic        sys_clk, srst;          // Clock and reset
	logic [5:0]  addr;                   // Bus from host model
	logic        wr_en, rd_en;
	logic [15:0] wr_data, rd_data;
	logic        rd_valid;
	logic [5:0]  st;                     // Frame control state
	logic [6:0]  ci, cq;                 // Converter samples
	logic        cen, craw, res, olp;    // Misc inputs
	logic        clk_en;
	logic [5:0]  sw [10];                // DAC source words
	logic [5:0]  di, dq;
	logic        run, pin, bat, pd, act, lpb, p1, drv, sns, nlf, nvc;
	logic [3:0]  rt;
	int          failures, n_compared;

	rtb_host_model host (.i_sys_clk(sys_clk), .i_rd_data(rd_data),
		.i_rd_valid(rd_valid), .o_addr(addr), .o_wr_en(wr_en),
		.o_wr_data(wr_data), .o_rd_en(rd_en));

	rtb_test_regs dut (.i_sys_clk(sys_clk), .i_srst(srst),
		.i_addr(addr), .i_wr_en(wr_en), .i_wr_data(wr_data),
		.i_rd_en(rd_en), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
		.i_present_state_code(st), .i_conv_i(ci), .i_conv_q(cq),
		.i_conv_enable(cen), .i_conv_clk_raw(craw),
		.o_conv_clk_en(clk_en), .i_mod_i(sw[0]), .i_mod_q(sw[1]),
		.i_filt_i(sw[2]), .i_filt_q(sw[3]), .i_noise_i(sw[4]),
		.i_noise_q(sw[5]), .i_mag_i(sw[6]), .i_mag_q(sw[7]),
		.i_dump_i(sw[8]), .i_dump_q(sw[9]), .o_dac_i(di),
		.o_dac_q(dq), .o_memory_selftest_run(run),
		.i_selftest_result(res), .o_selftest_pin(pin),
		.o_battery_monitor_test_out(bat),
		.o_analog_test_powerdown(pd), .o_analog_test_routing(rt),
		.o_routing_active(act), .o_if_loopback(lpb),
		.o_pin_first_to_node(p1), .o_pin_second_drives_node(drv),
		.o_pin_second_senses_node(sns),
		.i_control_node_open_loop(olp),
		.o_node_from_loop_filter(nlf), .o_node_from_vc_dac(nvc));

	// ----------------------------------------------------------------
	// Clock, compare and closing
	// ----------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	task automatic tick();
		@(posedge sys_clk);
		#1;
	endtask

	task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask

	// Read compare also demands the valid flag
	task automatic rchk(logic [5:0] a, logic [15:0] e);
		logic [15:0] d;
		logic        v;
		host.rd(a, d, v);
		chk("rd_valid", 16'h0001, {15'h0000, v});
		chk("rd_data", e, d);
		tick();
		chk("rd_valid", 16'h0000, {15'h0000, rd_valid});
	endtask

	task automatic report_and_stop();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		rchk(ADDR_STATE_INFO, 16'h002a);
		rchk(ADDR_CONV_TEST, {1'b0, 7'h5a, 1'b0, 7'h25});
		rchk(ADDR_DAC_TEST, 16'h0000);
		rchk(ADDR_TOP_TEST, 16'h0010);
		rchk(6'h30, 16'h0000);
		host.wr(ADDR_STATE_INFO, 16'hffff);
		@(posedge sys_clk) st <= 6'h15;
		rchk(ADDR_STATE_INFO, 16'h0015);
		$display("test reset done");
	endtask

	task automatic t_conv();
		host.wr(ADDR_CONV_TEST, 16'hffff);
		tick();
		chk("clk_en", 16'h0000, {15'h0000, clk_en});
		rchk(ADDR_CONV_TEST, {1'b1, 7'h5a, 1'b0, 7'h25});
		host.wr(ADDR_CONV_TEST, 16'h0000);
		tick();
		chk("clk_en", 16'h0001, {15'h0000, clk_en});
		@(posedge sys_clk) cen <= 1'b0;
		tick();
		chk("clk_en", 16'h0000, {15'h0000, clk_en});
		// Raw clock low must hold the gate low as well
		@(posedge sys_clk) begin
			cen  <= 1'b1;
			craw <= 1'b0;
		end
		tick();
		chk("clk_en", 16'h0000, {15'h0000, clk_en});
		@(posedge sys_clk) craw <= 1'b1;
		tick();
		chk("clk_en", 16'h0001, {15'h0000, clk_en});
		$display("test conv done");
	endtask

	// Every source code; in-phase override word 6'h2b equals the sample dump in-phase word sw[8]
	task automatic t_dac();
		logic [11:0] e;
		for (int k = 0; k < 8; k++) begin
			host.wr(ADDR_DAC_TEST, {1'b0, 3'(k), 6'h2b, 6'h14});
			tick();
			case (k)
				0:       e = {sw[0], sw[1]};
				1:       e = {6'h2b, 6'h14};
				2:       e = {ci[6:1], cq[6:1]};
				3:       e = {sw[2], sw[3]};
				4:       e = {sw[4], sw[5]};
				5:       e = {ci[5:0], cq[5:0]};
				6:       e = {sw[6], sw[7]};
				default: e = {sw[8], sw[9]};
			endcase
			chk("dac", {4'h0, e}, {4'h0, di, dq});
		end
		rchk(ADDR_DAC_TEST, {1'b0, 3'h7, 6'h2b, 6'h14});
		$display("test dac done");
	endtask

	// Output order: run pin bat pd route act loop p1 drv sns nlf nvc
	task automatic top_case(logic [15:0] d, logic o, logic [14:0] e);
		@(posedge sys_clk) olp <= o;
		host.wr(ADDR_TOP_TEST, d);
		tick();
		chk("top_outs", {1'b0, e}, {1'b0, run, pin, bat, pd, rt, act,
			lpb, p1, drv, sns, nlf, nvc});
		rchk(ADDR_TOP_TEST, d);
	endtask

	task automatic t_top();
		top_case(16'h00e7, 1'b1, 15'b111_0_0111_11110_00);
		top_case(16'h0007, 1'b1, 15'b000_0_0111_11101_01);
		top_case(16'h0009, 1'b0, 15'b000_0_0000_00000_10);
		top_case(16'h0017, 1'b1, 15'b000_1_0000_00000_01);
		// A failing self-test result must reach the pin as low
		@(posedge sys_clk) res <= 1'b0;
		top_case(16'h00e7, 1'b1, 15'b101_0_0111_11110_00);
		$display("test top done");
	endtask

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		failures   = 0;
		n_compared = 0;
		srst = 1'b1;
		st   = 6'h2a;
		ci   = 7'h5a;
		cq   = 7'h25;
		cen  = 1'b1;
		craw = 1'b1;
		res  = 1'b1;
		olp  = 1'b0;
		for (int j = 0; j < 10; j++)
			sw[j] = 6'(j * 5 + 3);
		repeat (6) @(posedge sys_clk);
		srst <= 1'b0;
		t_reset();
		t_conv();
		t_dac();
		t_top();
		report_and_stop();
	end

	// Whole run is about 105 cycles; allow 4000, nearly forty times that
	initial begin
		#(40 * 4000);
		failures++;
		report_and_stop();
	end
endmodule
`default_nettype wire
